// ### core/afd_seq.sv
// Diagnostic sequencer and result latch for a four-channel amplifier.
// Assumes raw fault comparators and overload flags arrive asynchronously;
// the I2C framing sits outside and pulses READ_START_I at each read.
`timescale 1ns/1ps
`default_nettype none
module afd_seq #(
  parameter int unsigned N_CH = 4,
  parameter int unsigned CHECK_CYC = afd_pkg::CHECK_CYC,
  parameter int unsigned PERM_CYC = afd_pkg::PERM_CYC,
  parameter int unsigned TURNON_CYC = afd_pkg::TURNON_CYC,
  parameter int unsigned NORM_MUTE_CYC = afd_pkg::NORM_MUTE_CYC,
  parameter int unsigned FAST_MUTE_CYC = afd_pkg::FAST_MUTE_CYC
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // Instruction bytes written by the host
  input wire logic [7:0] FIRST_INSTRUCTION_BYTE_I,
  input wire logic [7:0] SECOND_INSTRUCTION_BYTE_I,
  // Host read start (one cycle, from the I2C slave)
  input wire logic READ_START_I,
  // Turn-on diagnostic request (standby out with diag enable)
  input wire logic TURNON_REQ_I,
  // Raw analog comparator outputs, one bit per channel; thermal warnings are three shared bits
  input wire logic [N_CH-1:0] SHORT_GND_I,
  input wire logic [N_CH-1:0] SHORT_VS_I,
  input wire logic [N_CH-1:0] SHORT_ACROSS_I,
  input wire logic [N_CH-1:0] OPEN_LOAD_I,
  input wire logic [N_CH-1:0] OFFSET_HI_I,
  input wire logic [N_CH-1:0] OVERLOAD_I,
  input wire logic [N_CH-1:0] AC_PULSE_HI_I,
  input wire logic [N_CH-1:0] AC_PULSE_LO_I,
  input wire logic [2:0] THERMAL_WARN_I,
  // Mute request, AC threshold select and mute done
  input wire logic MUTE_REQ_I,
  output logic AC_LOW_TH_O,
  output logic MUTE_DONE_O,
  // Result bytes, held from the last read snapshot
  output logic [8*N_CH-1:0] RESULT_O,
  output logic [2:0] THERMAL_O
);
  localparam int unsigned MW = 32;
  localparam logic [1:0] AC_PULSES_MIN_W = 2'(afd_pkg::AC_PULSES_MIN);
  logic [N_CH-1:0] gnd_m, gnd_s, vs_m, vs_s, acr_m, acr_s, opn_m, opn_s;
  logic [N_CH-1:0] ofs_m, ofs_s, ovl_m, ovl_s, aph_m, aph_s, apl_m, apl_s;
  logic [2:0] thw_m, thw_s;
  logic mute_m, mute_s;
  logic diag_en, ofs_en, ac_en, fast_mute, ac_low;
  logic ofs_en_q;
  logic turnon_q;
  logic [N_CH-1:0] ofs_ok_q, scp_q, sgnd_st_q, svs_st_q, sacr_st_q, opn_st_q;
  logic [N_CH-1:0] perm_done_q;
  logic [1:0] pcnt_q [N_CH];
  logic [MW-1:0] turnon_cnt_q;
  logic [MW-1:0] mute_cnt_q;
  logic [8*N_CH-1:0] live, result_q;
  logic [2:0] therm_q;
  logic mute_done_q;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  always_ff @(posedge CLK_SYS_I) begin
    gnd_m <= SHORT_GND_I;
    gnd_s <= gnd_m;
    vs_m <= SHORT_VS_I;
    vs_s <= vs_m;
    acr_m <= SHORT_ACROSS_I;
    acr_s <= acr_m;
    opn_m <= OPEN_LOAD_I;
    opn_s <= opn_m;
    ofs_m <= OFFSET_HI_I;
    ofs_s <= ofs_m;
    ovl_m <= OVERLOAD_I;
    ovl_s <= ovl_m;
    aph_m <= AC_PULSE_HI_I;
    aph_s <= aph_m;
    apl_m <= AC_PULSE_LO_I;
    apl_s <= apl_m;
    thw_m <= THERMAL_WARN_I;
    thw_s <= thw_m;
    mute_m <= MUTE_REQ_I;
    mute_s <= mute_m;
  end

  // ****************************************************************
  // Instruction decode
  // ****************************************************************
  assign diag_en = FIRST_INSTRUCTION_BYTE_I[afd_pkg::B1_DIAG_EN];
  assign ofs_en = FIRST_INSTRUCTION_BYTE_I[afd_pkg::B1_OFS_EN];
  assign ac_en = SECOND_INSTRUCTION_BYTE_I[afd_pkg::B2_AC_EN];
  assign fast_mute = SECOND_INSTRUCTION_BYTE_I[afd_pkg::B2_FAST_MUTE];
  assign ac_low = SECOND_INSTRUCTION_BYTE_I[afd_pkg::B2_AC_LOW_TH];
  // Analog comparator picks 250/125 mApk pair when high, else 500/250
  assign AC_LOW_TH_O = ac_low;

  // ****************************************************************
  // Turn-on cycle timer
  // ****************************************************************
  // Open load is only trusted during the turn-on pulse window
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      turnon_q <= 1'b0;
      turnon_cnt_q <= '0;
    end else if (TURNON_REQ_I && diag_en) begin
      turnon_q <= 1'b1;
      turnon_cnt_q <= '0;
    end else if (turnon_q && turnon_cnt_q < TURNON_CYC[MW-1:0]) begin
      turnon_cnt_q <= turnon_cnt_q + 32'h1;
    end else if (READ_START_I) begin
      turnon_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Per-channel diagnostic state
  // ****************************************************************
  logic ofs_en_rise;
  assign ofs_en_rise = ofs_en & ~ofs_en_q;
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) ofs_en_q <= 1'b0;
    else ofs_en_q <= ofs_en;
  end

  genvar c;
  generate
    for (c = 0; c < N_CH; c++) begin : g_ch
      afd_pkg::afd_chan_t st_q;
      logic [MW-1:0] cnt_q;
      logic restart, pul, pul_q, rep;
      assign restart = READ_START_I | ofs_en_rise;
      // One count per rising edge; a long pulse must not count several times
      assign pul = ac_low ? apl_s[c] : aph_s[c];
      // Shorts are kept only once a permanent cycle has run or while a turn-on cycle is active
      assign rep = perm_done_q[c] | turnon_q;
      always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
          st_q <= afd_pkg::ST_IDLE;
          cnt_q <= '0;
          perm_done_q[c] <= 1'b0;
        end else begin
          case (st_q)
            afd_pkg::ST_IDLE: begin
              cnt_q <= '0;
              if (diag_en && ovl_s[c]) st_q <= afd_pkg::ST_CHECK;
            end
            afd_pkg::ST_CHECK: begin
              cnt_q <= cnt_q + 32'h1;
              if (cnt_q >= CHECK_CYC[MW-1:0] - 32'h1) begin
                cnt_q <= '0;
                st_q <= ovl_s[c] ? afd_pkg::ST_DIAG : afd_pkg::ST_IDLE;
              end
            end
            afd_pkg::ST_DIAG: begin
              cnt_q <= cnt_q + 32'h1;
              if (cnt_q >= PERM_CYC[MW-1:0] - 32'h1) begin
                st_q <= afd_pkg::ST_DONE;
                perm_done_q[c] <= 1'b1;
              end
            end
            afd_pkg::ST_DONE: begin
              // Next cycle only after a read re-arms
              if (READ_START_I) begin
                st_q <= afd_pkg::ST_IDLE;
                perm_done_q[c] <= 1'b0;
              end
            end
            default: st_q <= afd_pkg::ST_IDLE;
          endcase
        end
      end

      // Stability trackers: true only if held since the last restart; scp_q sets on any overload since then
      always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
          ofs_ok_q[c] <= 1'b0;
          scp_q[c] <= 1'b0;
          sgnd_st_q[c] <= 1'b0;
          svs_st_q[c] <= 1'b0;
          sacr_st_q[c] <= 1'b0;
          opn_st_q[c] <= 1'b0;
          pcnt_q[c] <= 2'h0;
        end else if (restart) begin
          ofs_ok_q[c] <= ofs_en;
          scp_q[c] <= ovl_s[c];
          sgnd_st_q[c] <= diag_en;
          svs_st_q[c] <= diag_en;
          sacr_st_q[c] <= diag_en;
          opn_st_q[c] <= diag_en;
          pcnt_q[c] <= 2'h0;
        end else begin
          ofs_ok_q[c] <= ofs_ok_q[c] & ofs_s[c] & ofs_en;
          scp_q[c] <= scp_q[c] | ovl_s[c];
          sgnd_st_q[c] <= sgnd_st_q[c] & gnd_s[c];
          svs_st_q[c] <= svs_st_q[c] & vs_s[c];
          sacr_st_q[c] <= sacr_st_q[c] & acr_s[c];
          opn_st_q[c] <= opn_st_q[c] & opn_s[c] & turnon_q;
          if (ac_en && pul && !pul_q && pcnt_q[c] != 2'h3)
            pcnt_q[c] <= pcnt_q[c] + 2'h1;
        end
      end

      always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) pul_q <= 1'b0;
        else pul_q <= pul;
      end

      // Ranking: shorts mask across-load and open; both shorts coexist
      logic hi_pri, twopen;
      assign hi_pri = sgnd_st_q[c] | svs_st_q[c];
      assign twopen = ac_en & ~scp_q[c] & (pcnt_q[c] < AC_PULSES_MIN_W);
      assign live[8*c +: 8] = {
        1'b0,
        turnon_q,
        twopen,
        ofs_ok_q[c] & ~scp_q[c],
        opn_st_q[c] & ~hi_pri & ~sacr_st_q[c] & turnon_q,
        sacr_st_q[c] & ~hi_pri & rep,
        svs_st_q[c] & rep,
        sgnd_st_q[c] & rep
      };
    end
  endgenerate

  // ****************************************************************
  // Result snapshot at read start
  // ****************************************************************
  // Whole-vector capture keeps all bytes of one read consistent
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      result_q <= {N_CH{afd_pkg::RES_RST}};
      therm_q <= 3'h0;
    end else if (READ_START_I) begin
      result_q <= live;
      therm_q <= thw_s;
    end
  end
  assign RESULT_O = result_q;
  assign THERMAL_O = therm_q;

  // ****************************************************************
  // Mute timer
  // ****************************************************************
  // Fast mute bounds the ramp so it ends before 1.5 ms
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      mute_cnt_q <= '0;
      mute_done_q <= 1'b0;
    end else if (!mute_s) begin
      mute_cnt_q <= '0;
      mute_done_q <= 1'b0;
    end else if (!mute_done_q) begin
      mute_cnt_q <= mute_cnt_q + 32'h1;
      if (mute_cnt_q >= (fast_mute ? FAST_MUTE_CYC[MW-1:0] - 32'h3 : NORM_MUTE_CYC[MW-1:0]))
        mute_done_q <= 1'b1;
    end
  end
  assign MUTE_DONE_O = mute_done_q;
endmodule : afd_seq
`default_nettype wire

// ### core/afd_pkg.sv
// Constants shared by the amplifier fault diagnostic sequencer.
// Assumes a 250 MHz system clock and analog comparators outside this logic.
//
// Function
// - Flag offset fault when a channel's DC offset exceeds 2 V magnitude.
// - Offset test runs from previous read or offset-enable set, until current read.
// - Report offset only if excess persisted through the whole test interval.
// - Short-circuit protection during a test suppresses offset and AC load results.
// - AC load diagnostic active only while second byte bit D2 is 1.
// - Second byte D7 picks threshold pair 500/250 or 250/125 mApk.
// - Tweeter present only after 3 pulses above threshold, else open tweeter.
// - Coexisting faults: report at least one first, others on later reads.
// - Short to ground or supply outranks across-load and open; both shorts report together.
// - Permanent diagnostic never reports open load; only turn-on cycle does.
// - A fault is reported only if stable for the whole measurement period.
// - Every read re-arms all cycles and returns the preceding cycle's data; the code re-arms a channel only in ST_DONE and turn-on only after its count.
// - Three distinct thermal warnings appear in the readable diagnostic data.
// - With second byte D5 set, mute transition completes within 1.5 ms.
// - First byte D6 enables diagnostics when 1, disables when 0.
// - Overload persisting at 1 ms check starts a 100 ms permanent cycle.
package afd_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned CHECK_US = 1000;
  localparam int unsigned PERM_MS = 100;
  localparam int unsigned TURNON_MS = 100;
  localparam int unsigned FAST_MUTE_US = 1500;
  localparam int unsigned NORM_MUTE_US = 20000;
  localparam int unsigned CHECK_CYC = CHECK_US * CLK_MHZ;
  localparam int unsigned PERM_CYC = PERM_MS * 1000 * CLK_MHZ;
  localparam int unsigned TURNON_CYC = TURNON_MS * 1000 * CLK_MHZ;
  localparam int unsigned FAST_MUTE_CYC = FAST_MUTE_US * CLK_MHZ - 1;
  localparam int unsigned NORM_MUTE_CYC = NORM_MUTE_US * CLK_MHZ;
  localparam int unsigned AC_PULSES_MIN = 3;
  // Instruction byte bit positions
  localparam int unsigned B1_DIAG_EN = 6;
  localparam int unsigned B1_OFS_EN = 5;
  localparam int unsigned B2_AC_LOW_TH = 7;
  localparam int unsigned B2_FAST_MUTE = 5;
  localparam int unsigned B2_AC_EN = 2;
  // Per-channel result byte layout
  localparam int unsigned RB_SGND = 0;
  localparam int unsigned RB_SVS = 1;
  localparam int unsigned RB_SACR = 2;
  localparam int unsigned RB_OPEN = 3;
  localparam int unsigned RB_OFS = 4;
  localparam int unsigned RB_TWOPEN = 5;
  localparam int unsigned RB_TURNON = 6;
  localparam logic [7:0] RES_RST = 8'h00;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CHECK = 4'b0010,
    ST_DIAG = 4'b0100,
    ST_DONE = 4'b1000
  } afd_chan_t;
endpackage : afd_pkg

// ### verif/afd_host.sv
// Host model: holds the two instruction bytes and issues read pulses.
// Assumes one clock shared with the sequencer.
`timescale 1ns/1ps
`default_nettype none
module afd_host (
  // Clock
  input wire logic clk_i,
  // Instruction bytes and read strobe
  output logic [7:0] first_o,
  output logic [7:0] second_o,
  output logic read_o
);
  initial begin
    first_o = 8'h00;
    second_o = 8'h00;
    read_o = 1'b0;
  end
  // Callers drop fast mute again as soon as the ramp has ended
  task automatic set_bytes(input logic [7:0] b1, input logic [7:0] b2);
    @(posedge clk_i);
    first_o <= b1;
    second_o <= b2;
  endtask : set_bytes
  // Callers read twice to see a change; AC tone spans the whole period
  task automatic read_pulse();
    @(posedge clk_i);
    read_o <= 1'b1;
    @(posedge clk_i);
    read_o <= 1'b0;
    @(posedge clk_i);
  endtask : read_pulse
endmodule : afd_host
`default_nettype wire

// ### verif/afd_seq_chk.sv
// Port checker for the diagnostic sequencer.
// Assumes instruction bytes are held as levels around reads.
`timescale 1ns/1ps
`default_nettype none
module afd_seq_chk #(
  parameter int unsigned N_CH = 4
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [7:0] FIRST_INSTRUCTION_BYTE_I,
  input wire logic [7:0] SECOND_INSTRUCTION_BYTE_I,
  input wire logic READ_START_I,
  input wire logic MUTE_REQ_I,
  input wire logic AC_LOW_TH_O,
  input wire logic MUTE_DONE_O,
  input wire logic [8*N_CH-1:0] RESULT_O,
  input wire logic [2:0] THERMAL_O
);
  // ********
  // Checks
  // ********
  localparam logic [8*N_CH-1:0] LSB = {N_CH{8'h01}};
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  sequence s_read; READ_START_I; endsequence
  sequence s_quiet5; !MUTE_REQ_I [*5]; endsequence
  property p_hold; !READ_START_I |=> $stable(RESULT_O); endproperty
  a_hold: assert property (p_hold) else $error("result moved without a read");
  property p_therm; !READ_START_I |=> $stable(THERMAL_O); endproperty
  a_therm: assert property (p_therm) else $error("thermal moved without a read");
  property p_ac_th; AC_LOW_TH_O == SECOND_INSTRUCTION_BYTE_I[7]; endproperty
  a_ac_th: assert property (p_ac_th) else $error("threshold select wrong");
  property p_rank; (((RESULT_O >> 0) | (RESULT_O >> 1)) & ((RESULT_O >> 2) | (RESULT_O >> 3)) & LSB) == '0; endproperty
  a_rank: assert property (p_rank) else $error("short ranking wrong");
  property p_open; ((RESULT_O >> 3) & ~(RESULT_O >> 6) & LSB) == '0; endproperty
  a_open: assert property (p_open) else $error("open load outside turn-on");
  property p_tw; s_read ##0 !SECOND_INSTRUCTION_BYTE_I[2] |=> ((RESULT_O >> 5) & LSB) == '0; endproperty
  a_tw: assert property (p_tw) else $error("tweeter flag with AC off");
  property p_top; (RESULT_O & (LSB << 7)) == '0; endproperty
  a_top: assert property (p_top) else $error("spare result bit set");
  property p_mute; s_quiet5 |-> !MUTE_DONE_O; endproperty
  a_mute: assert property (p_mute) else $error("mute done stuck");
endmodule : afd_seq_chk
`default_nettype wire

// ### verif/afd_seq_tb.sv
// Self-checking bench for the diagnostic sequencer.
// Assumes shortened counts; the host model drives bytes and reads.
`timescale 1ns/1ps
`default_nettype none
module afd_seq_tb;
  localparam int unsigned MUTE_N = 50;
  localparam int unsigned FAST_N = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ton = 1'b0;
  logic mreq = 1'b0;
  logic [3:0] sgnd = '0, svs = '0, sacr = '0, opn = '0, ofs = '0, ovl = '0, achi = '0, aclo = '0;
  logic [2:0] thw = '0;
  logic [7:0] b1, b2;
  logic rd, ac_th, mdone;
  logic [31:0] res;
  logic [2:0] therm;
  int errors = 0;
  int checks_done = 0;
  int n;
  initial begin
    forever #2 clk = ~clk;
  end
  afd_host u_host (.clk_i(clk), .first_o(b1), .second_o(b2), .read_o(rd));
  afd_seq #(.CHECK_CYC(10), .PERM_CYC(50), .TURNON_CYC(50), .NORM_MUTE_CYC(MUTE_N),
    .FAST_MUTE_CYC(FAST_N)) DUT (
    .CLK_SYS_I(clk), .RST_I(rst), .FIRST_INSTRUCTION_BYTE_I(b1), .SECOND_INSTRUCTION_BYTE_I(b2),
    .READ_START_I(rd), .TURNON_REQ_I(ton), .SHORT_GND_I(sgnd), .SHORT_VS_I(svs), .SHORT_ACROSS_I(sacr),
    .OPEN_LOAD_I(opn), .OFFSET_HI_I(ofs), .OVERLOAD_I(ovl), .AC_PULSE_HI_I(achi), .AC_PULSE_LO_I(aclo),
    .THERMAL_WARN_I(thw), .MUTE_REQ_I(mreq), .AC_LOW_TH_O(ac_th), .MUTE_DONE_O(mdone),
    .RESULT_O(res), .THERMAL_O(therm));
  // ********
  // Tasks
  // ********
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd1();
    u_host.read_pulse();
    #1;
  endtask : rd1
  task automatic give_verdict();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  task automatic wait_done(output int k);
    k = 0;
    while (mdone !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    if (k == 200) begin
      errors++;
      give_verdict();
    end
  endtask : wait_done
  initial begin
    cyc(3);
    rst <= 1'b0;
    cyc(1);
    #1;
    chk(res, 32'h0);
    chk({therm, mdone}, 32'h0);
    for (int t = 0; t < 2; t++) begin
      u_host.set_bytes(8'h40, {t[0], 7'h00});
      #1;
      chk(ac_th, t[0]);
    end
    // Ch3 open with no overload must stay hidden outside turn-on
    cyc(1);
    {sgnd, svs, sacr, ovl, opn} <= {4'b0111, 4'b0100, 4'b0010, 4'b0111, 4'b1000};
    cyc(4);
    rd1();
    cyc(100);
    rd1();
    chk(res & 32'h1f1f1f1f, 32'h00030101);
    cyc(100);
    {sgnd, svs, sacr, ovl, opn} <= '0;
    rd1();
    chk(res & 32'h1f1f1f1f, 32'h00030101);
    cyc(100);
    rd1();
    chk(res & 32'h1f1f1f1f, 32'h0);
    cyc(1);
    opn <= 4'b0001;
    ton <= 1'b1;
    cyc(1);
    ton <= 1'b0;
    cyc(4);
    rd1();
    cyc(60);
    rd1();
    chk(res & 32'h1f1f1f1f, 32'h00000008);
    rd1();
    chk(res & 32'h1f1f1f1f, 32'h0);
    cyc(1);
    opn <= '0;
    u_host.set_bytes(8'h60, 8'h00);
    ofs <= 4'b1000;
    cyc(4);
    rd1();
    cyc(40);
    rd1();
    chk(res[28], 1'b1);
    cyc(10);
    ofs <= '0;
    cyc(3);
    ofs <= 4'b1000;
    cyc(30);
    rd1();
    chk(res[28], 1'b0);
    for (int t = 0; t < 2; t++) begin
      u_host.set_bytes(8'h40, {t[0], 7'h04});
      {ofs, ovl} <= {4'h0, 4'b0100};
      cyc(4);
      rd1();
      for (int p = 0; p < 3; p++) begin
        cyc(1);
        {aclo, achi} <= (t == 1) ? {((p < 2) ? 4'b0011 : 4'b0001), 4'h0} : {4'h0, ((p < 2) ? 4'b0011 : 4'b0001)};
        cyc(3);
        {aclo, achi} <= '0;
        cyc(4);
      end
      rd1();
      chk({res[29], res[21], res[13], res[5]}, 4'b1010);
    end
    for (int t = 5; t > 0; t -= 3) begin
      cyc(1);
      {ovl, thw} <= {4'h0, t[2:0]};
      cyc(4);
      rd1();
      chk(therm, t[2:0]);
    end
    u_host.set_bytes(8'h40, 8'h00);
    mreq <= 1'b1;
    wait_done(n);
    chk(n >= MUTE_N && n <= MUTE_N + 6, 1'b1);
    cyc(1);
    mreq <= 1'b0;
    cyc(6);
    #1;
    chk(mdone, 1'b0);
    u_host.set_bytes(8'h40, 8'h20);
    mreq <= 1'b1;
    wait_done(n);
    chk(n >= FAST_N - 4 && n <= FAST_N + 1, 1'b1);
    u_host.set_bytes(8'h40, 8'h00);
    mreq <= 1'b0;
    give_verdict();
  end
endmodule : afd_seq_tb
bind afd_seq afd_seq_chk #(.N_CH(N_CH)) u_chk (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
  .FIRST_INSTRUCTION_BYTE_I(FIRST_INSTRUCTION_BYTE_I), .SECOND_INSTRUCTION_BYTE_I(SECOND_INSTRUCTION_BYTE_I),
  .READ_START_I(READ_START_I), .MUTE_REQ_I(MUTE_REQ_I), .AC_LOW_TH_O(AC_LOW_TH_O), .MUTE_DONE_O(MUTE_DONE_O),
  .RESULT_O(RESULT_O), .THERMAL_O(THERMAL_O));
`default_nettype wire
